// >>> rsw_pkg.sv
package rsw_pkg;
  // Register offsets on the CPU and background buses
  localparam logic [7:0] OFS_CAUSE = 8'h00;
  localparam logic [7:0] OFS_DEBUG = 8'h01;
  localparam logic [7:0] OFS_OPT1  = 8'h02;
  localparam logic [7:0] OFS_OPT2  = 8'h03;
  // Service keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Values after reset
  localparam logic [7:0] CAUSE_POR_RST = 8'h82;
  localparam logic [7:0] OPT1_RST      = 8'hc0;
  localparam logic [7:0] OPT2_RST      = 8'h00;
  // Cause register bit positions
  localparam int BIT_POR  = 7;
  localparam int BIT_PIN  = 6;
  localparam int BIT_WD   = 5;
  localparam int BIT_ILLEGAL_OPCODE_FLAG = 4;
  localparam int BIT_ILLEGAL_ADDRESS_FLAG = 3;
  localparam int BIT_LOC  = 2;
  localparam int BIT_LV   = 1;
  // Field positions
  localparam int BIT_FORCE = 0;
  localparam int TSEL_HI   = 7;
  localparam int TSEL_LO   = 6;
  localparam int BIT_STOP  = 5;
  localparam int BIT_SER2  = 4;
  localparam int BIT_I2C   = 3;
  localparam int BIT_CLKS  = 7;
  localparam int BIT_WIN   = 6;
  // Watchdog terminal counts (overflow count minus one)
  localparam logic [17:0] LPO_TC1 = 18'h0001f;
  localparam logic [17:0] LPO_TC2 = 18'h000ff;
  localparam logic [17:0] LPO_TC3 = 18'h003ff;
  localparam logic [17:0] BUS_TC1 = 18'h01fff;
  localparam logic [17:0] BUS_TC2 = 18'h0ffff;
  localparam logic [17:0] BUS_TC3 = 18'h3ffff;
  // Service window opening counts, bus clock
  localparam logic [17:0] BUS_WIN1 = 18'h01800;
  localparam logic [17:0] BUS_WIN2 = 18'h0c000;
  localparam logic [17:0] BUS_WIN3 = 18'h30000;
  // Timing
  localparam int CLK_HZ        = 20000000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int LPO_HZ        = 1000;
  localparam int LPO_DIV       = CLK_HZ / LPO_HZ;
  localparam int RST_HOLD_NS   = 400;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } rsw_state_e;
endpackage

// >>> rsw_reset_watchdog.sv
`timescale 1ns/1ps
// Summary of operation
// - At reset entry each cause flag copies whether its source is active then.
// - A debug-forced reset leaves every cause flag cleared.
// - With watchdog on, cause-address writes other than 55h/AAh reset at once.
// - Writing 55h then AAh restarts the watchdog, cause flags untouched.
// - Power-on reset sets the power-on flag and the low-voltage flag.
// - Bit 6 flags a reset from the low external reset pin.
// - Bit 5 flags watchdog timeout; never fires while watchdog is disabled.
// - Bit 4 flags illegal opcode, including disallowed stop or background instruction.
// - Bit 3 flags access to an unimplemented address.
// - Bit 2 flags loss of the external clock.
// - Bit 1 flags an enabled low-voltage trip; bit 0 reads zero.
// - Debug reset register ignores CPU writes, takes background writes, reads 00h.
// - Options register takes only its first write after reset, always readable.
// - Timeout field bits 7:6 select the period; zero disables the watchdog.
// - Overflow after 2^5/2^8/2^10 slow ticks or 2^13/2^16/2^18 bus cycles.
// - Bus clock window opens after 6144, 49152 or 196608 cycles.
// - Stop-allow bit 5; stop with it clear forces illegal-opcode reset.
// - Write-once bit 4 picks the second serial port pin pair.
// - Write-once bit 3 picks the I2C pin pair.
// - Write-once clock select: zero slow 1 kHz tick, one bus clock.
// - Window mode, bus clock only: any cause-address write in first 75% resets.
module rsw_reset_watchdog #(
  parameter int LPO_DIV = rsw_pkg::LPO_DIV
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       cpu_wr_en,
  input  wire logic       cpu_rd_en,
  input  wire logic [7:0] cpu_addr,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  input  wire logic       bdm_wr_en,
  input  wire logic [7:0] bdm_addr,
  input  wire logic [7:0] bdm_wdata,
  input  wire logic       background_mode_enable,
  input  wire logic       illegal_opcode,
  input  wire logic       stop_exec,
  input  wire logic       enter_background_instruction,
  input  wire logic       illegal_address,
  input  wire logic       clock_loss,
  input  wire logic       reset_pin_b,
  input  wire logic       low_voltage_trip,
  input  wire logic       low_voltage_reset_enable,
  output logic            mcu_reset,
  output logic            stop_allow,
  output logic            serial2_pin_location,
  output logic            i2c_pin_location,
  output logic            watchdog_enable
);
  localparam int LW = $clog2(LPO_DIV);

  logic             rst_s1_ff;
  logic             rst_s2_ff;
  logic             rst_n_i;
  logic             pin_s1_ff;
  logic             pin_s2_ff;
  logic             lv_s1_ff;
  logic             lv_s2_ff;
  logic [LW-1:0]    lpo_cnt_ff;
  logic             lpo_tick_ff;
  rsw_pkg::rsw_state_e state_ff;
  rsw_pkg::rsw_state_e nxt_state;
  logic [3:0]       hold_cnt_ff;
  logic [7:0]       cause_ff;
  logic [7:0]       nxt_cause;
  logic [7:0]       opt1_ff;
  logic [7:0]       opt2_ff;
  logic             opt1_done_ff;
  logic             opt2_done_ff;
  logic [17:0]      wd_cnt_ff;
  logic             key_armed_ff;
  logic [7:0]       rdata_ff;
  logic             sys_reset_ff;
  logic             wd_en_ff;
  logic             in_run;
  logic             wr_cause;
  logic             wr_opt1;
  logic             wr_opt2;
  logic             wd_en;
  logic             wd_bus;
  logic             wd_tick;
  logic [17:0]      wd_tc;
  logic [17:0]      wd_win;
  logic             wd_timeout;
  logic             bad_key;
  logic             early_wr;
  logic             service;
  logic             wd_fire;
  logic             illegal_opcode_flag_src;
  logic             lv_src;
  logic             force_rst;
  logic [7:0]       cause_now;
  logic             entry;
  logic [7:0]       rd_mux;

  function automatic logic [17:0] sel_tc(input logic [1:0] tsel, input logic bus);
    logic [17:0] r;
    r = 18'h00000;
    unique case (tsel)
      2'b01:   r = bus ? rsw_pkg::BUS_TC1 : rsw_pkg::LPO_TC1;
      2'b10:   r = bus ? rsw_pkg::BUS_TC2 : rsw_pkg::LPO_TC2;
      2'b11:   r = bus ? rsw_pkg::BUS_TC3 : rsw_pkg::LPO_TC3;
      default: r = 18'h00000;
    endcase
    return r;
  endfunction

  function automatic logic [17:0] sel_win(input logic [1:0] tsel);
    logic [17:0] r;
    r = 18'h00000;
    unique case (tsel)
      2'b01:   r = rsw_pkg::BUS_WIN1;
      2'b10:   r = rsw_pkg::BUS_WIN2;
      2'b11:   r = rsw_pkg::BUS_WIN3;
      default: r = 18'h00000;
    endcase
    return r;
  endfunction

  // Reset release synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_n_i = rst_s2_ff;

  // Pin-level sources cross in through two flops
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      lv_s1_ff  <= 1'b0;
      lv_s2_ff  <= 1'b0;
    end else begin
      pin_s1_ff <= reset_pin_b;
      pin_s2_ff <= pin_s1_ff;
      lv_s1_ff  <= low_voltage_trip;
      lv_s2_ff  <= lv_s1_ff;
    end
  end

  // Slow 1 kHz tick as an enable pulse; phase is not reset by service
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lpo_cnt_ff  <= '0;
      lpo_tick_ff <= 1'b0;
    end else begin
      lpo_tick_ff <= (lpo_cnt_ff == LW'(LPO_DIV - 1));
      lpo_cnt_ff  <= (lpo_cnt_ff == LW'(LPO_DIV - 1)) ? '0 : lpo_cnt_ff + 1'b1;
    end
  end

  assign in_run   = (state_ff == rsw_pkg::ST_RUN);
  assign wr_cause = cpu_wr_en & (cpu_addr == rsw_pkg::OFS_CAUSE) & in_run;
  assign wr_opt1  = cpu_wr_en & (cpu_addr == rsw_pkg::OFS_OPT1) & in_run & ~opt1_done_ff;
  assign wr_opt2  = cpu_wr_en & (cpu_addr == rsw_pkg::OFS_OPT2) & in_run & ~opt2_done_ff;

  assign wd_en   = wd_en_ff;
  assign wd_bus  = opt2_ff[rsw_pkg::BIT_CLKS];
  assign wd_tick = wd_bus | lpo_tick_ff;
  assign wd_tc   = sel_tc(opt1_ff[rsw_pkg::TSEL_HI:rsw_pkg::TSEL_LO], wd_bus);
  assign wd_win  = sel_win(opt1_ff[rsw_pkg::TSEL_HI:rsw_pkg::TSEL_LO]);

  assign wd_timeout = wd_en & wd_tick & (wd_cnt_ff == wd_tc);
  assign bad_key    = wr_cause & wd_en & (cpu_wdata != rsw_pkg::KEY_FIRST)
                      & (cpu_wdata != rsw_pkg::KEY_SECOND);
  // The window has no opening figure for the slow tick, so it applies on the bus clock only
  assign early_wr   = wr_cause & wd_en & opt2_ff[rsw_pkg::BIT_WIN] & wd_bus
                      & (wd_cnt_ff < wd_win);
  assign service    = wr_cause & (cpu_wdata == rsw_pkg::KEY_SECOND) & key_armed_ff
                      & ~early_wr;
  assign wd_fire    = wd_timeout | bad_key | early_wr;

  assign illegal_opcode_flag_src  = illegal_opcode
                     | (stop_exec & ~opt1_ff[rsw_pkg::BIT_STOP])
                     | (enter_background_instruction & ~background_mode_enable);
  assign lv_src    = lv_s2_ff & low_voltage_reset_enable;
  // User-bus writes to the debug register never reach this term
  assign force_rst = bdm_wr_en & (bdm_addr == rsw_pkg::OFS_DEBUG)
                     & bdm_wdata[rsw_pkg::BIT_FORCE];

  assign cause_now = {1'b0,
                      ~pin_s2_ff,
                      wd_fire,
                      illegal_opcode_flag_src,
                      illegal_address,
                      clock_loss,
                      lv_src,
                      1'b0};
  assign entry     = in_run & (force_rst | (|cause_now));
  assign nxt_cause = force_rst ? 8'h00 : cause_now;
  assign nxt_state = entry ? rsw_pkg::ST_HOLD :
                     (!in_run && hold_cnt_ff == 4'h0) ? rsw_pkg::ST_RUN : state_ff;

  // Reset sequencer; a source still active at the end of hold re-enters
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff     <= rsw_pkg::ST_RUN;
      hold_cnt_ff  <= 4'h0;
      sys_reset_ff <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      hold_cnt_ff  <= entry ? 4'(rsw_pkg::RST_HOLD_CYC - 1) :
                      (hold_cnt_ff != 4'h0) ? hold_cnt_ff - 4'h1 : 4'h0;
      sys_reset_ff <= (nxt_state == rsw_pkg::ST_HOLD);
    end
  end

  // Cause flags change only on reset entry
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cause_ff <= rsw_pkg::CAUSE_POR_RST;
    end else if (entry) begin
      cause_ff <= nxt_cause;
    end
  end

  // Write-once options; an internal reset reopens them
  // The enable is kept as its own flop so the output pin never sees a gate
  // The counter is not restarted by the options write; software services first
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt1_ff      <= rsw_pkg::OPT1_RST;
      opt1_done_ff <= 1'b0;
      wd_en_ff     <= |rsw_pkg::OPT1_RST[rsw_pkg::TSEL_HI:rsw_pkg::TSEL_LO];
    end else if (!in_run) begin
      opt1_ff      <= rsw_pkg::OPT1_RST;
      opt1_done_ff <= 1'b0;
      wd_en_ff     <= |rsw_pkg::OPT1_RST[rsw_pkg::TSEL_HI:rsw_pkg::TSEL_LO];
    end else if (wr_opt1) begin
      opt1_ff      <= {cpu_wdata[7:3], 3'b000};
      opt1_done_ff <= 1'b1;
      wd_en_ff     <= |cpu_wdata[rsw_pkg::TSEL_HI:rsw_pkg::TSEL_LO];
    end
  end

  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt2_ff      <= rsw_pkg::OPT2_RST;
      opt2_done_ff <= 1'b0;
    end else if (!in_run) begin
      opt2_ff      <= rsw_pkg::OPT2_RST;
      opt2_done_ff <= 1'b0;
    end else if (wr_opt2) begin
      opt2_ff      <= {cpu_wdata[7:6], 6'b000000};
      opt2_done_ff <= 1'b1;
    end
  end

  // Watchdog counter and key sequencing
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_cnt_ff    <= 18'h00000;
      key_armed_ff <= 1'b0;
    end else if (!in_run || service || !wd_en) begin
      wd_cnt_ff    <= 18'h00000;
      key_armed_ff <= 1'b0;
    end else begin
      if (wd_tick) begin
        wd_cnt_ff <= wd_cnt_ff + 18'h00001;
      end
      if (wr_cause) begin
        key_armed_ff <= (cpu_wdata == rsw_pkg::KEY_FIRST);
      end
    end
  end

  assign rd_mux = (cpu_addr == rsw_pkg::OFS_CAUSE) ? cause_ff :
                  (cpu_addr == rsw_pkg::OFS_OPT1)  ? opt1_ff  :
                  (cpu_addr == rsw_pkg::OFS_OPT2)  ? opt2_ff  :
                  8'h00;

  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else if (cpu_rd_en) begin
      rdata_ff <= rd_mux;
    end
  end

  assign cpu_rdata            = rdata_ff;
  assign mcu_reset            = sys_reset_ff;
  assign stop_allow           = opt1_ff[rsw_pkg::BIT_STOP];
  assign serial2_pin_location = opt1_ff[rsw_pkg::BIT_SER2];
  assign i2c_pin_location     = opt1_ff[rsw_pkg::BIT_I2C];
  assign watchdog_enable      = wd_en;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_i);

  a_force_clears: assert property (force_rst && in_run |=> cause_ff == 8'h00)
    else $error("forced reset left a cause flag set");
  a_bad_key_reset: assert property (bad_key |=> sys_reset_ff && cause_ff[5])
    else $error("bad key did not cause watchdog reset");
  a_service_keeps: assert property (service |=> wd_cnt_ff == 18'h00000 && $stable(cause_ff))
    else $error("service did not restart counter cleanly");
  a_wd_needs_en: assert property ($rose(sys_reset_ff) && cause_ff[5] |-> $past(wd_en))
    else $error("watchdog reset while disabled");
  a_opt1_once: assert property (opt1_done_ff && in_run && !entry |=> $stable(opt1_ff))
    else $error("options register changed after first write");
  a_dbg_reads_zero: assert property (cpu_rd_en && cpu_addr == rsw_pkg::OFS_DEBUG
                                     |=> rdata_ff == 8'h00)
    else $error("debug register read not zero");
  a_cause_bit0: assert property (cpu_rd_en && cpu_addr == rsw_pkg::OFS_CAUSE && !entry
                                 |=> !rdata_ff[0] && rdata_ff == cause_ff)
    else $error("cause read wrong");
  a_hold_len: assert property ($rose(sys_reset_ff) |-> sys_reset_ff [*8] ##1 !sys_reset_ff)
    else $error("reset hold length wrong");
  a_early_window: assert property (early_wr |=> sys_reset_ff ##0 cause_ff[5])
    else $error("early window write did not reset");
  a_stop_illegal: assert property (in_run && stop_exec && !opt1_ff[5] && !force_rst
                                   |=> cause_ff[4])
    else $error("disallowed stop missed illegal opcode flag");
  a_pin_flag: assert property (in_run && !pin_s2_ff && !force_rst |=> cause_ff[6])
    else $error("pin reset flag missing");
  a_timeout_flag: assert property (wd_timeout |=> cause_ff[5] ##1 sys_reset_ff)
    else $error("timeout did not raise watchdog reset");
  // Enable flop must always agree with the timeout field it shadows
  a_wd_en_tracks: assert property (wd_en_ff == (|opt1_ff[7:6]))
    else $error("watchdog enable disagrees with timeout field");
  a_count_restart: assert property (!in_run |=> wd_cnt_ff == 18'h00000)
    else $error("watchdog count not restarted by reset");
  a_opt2_once: assert property (opt2_done_ff && in_run && !entry |=> $stable(opt2_ff))
    else $error("second options register changed after first write");
  a_lv_flag: assert property (in_run && lv_src && !force_rst |=> cause_ff[1])
    else $error("low-voltage reset flag missing");
  a_bad_addr_flag: assert property (in_run && illegal_address && !force_rst |=> cause_ff[3])
    else $error("illegal address flag missing");
  a_clk_loss_flag: assert property (in_run && clock_loss && !force_rst |=> cause_ff[2])
    else $error("clock loss flag missing");

  c_service: cover property (key_armed_ff ##[1:20] service);
  c_force: cover property (force_rst && in_run);
  c_timeout: cover property (wd_timeout);
  c_early: cover property (early_wr);
  c_window_service: cover property (service && opt2_ff[rsw_pkg::BIT_WIN]);

endmodule // rsw_reset_watchdog

// >>> rsw_debug_host.sv
`timescale 1ns/1ps
module rsw_debug_host (
  input  wire logic       clk,
  output logic            bdm_wr_en,
  output logic      [7:0] bdm_addr,
  output logic      [7:0] bdm_wdata
);
  // Idle lines carry junk so a stale value is never mistaken for a command
  initial begin
    bdm_wr_en = 1'b0;
    bdm_addr  = 8'h5a;
    bdm_wdata = 8'ha5;
  end

  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    bdm_wr_en = 1'b1;
    bdm_addr  = addr;
    bdm_wdata = data;
    @(negedge clk);
    bdm_wr_en = 1'b0;
    bdm_addr  = ~addr;
    bdm_wdata = ~data;
  endtask
endmodule // rsw_debug_host

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       clk;
  logic       rst_b;
  logic       cpu_wr_en;
  logic       cpu_rd_en;
  logic [7:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic [7:0] cpu_rdata;
  logic       bdm_wr_en;
  logic [7:0] bdm_addr;
  logic [7:0] bdm_wdata;
  logic [6:0] src;
  logic       mcu_reset;
  logic       stop_allow;
  logic       serial2_pin_location;
  logic       i2c_pin_location;
  logic       watchdog_enable;
  logic [7:0] rd;
  int         miscompares;
  int         total_checks;
  int         lat;

  rsw_reset_watchdog #(.LPO_DIV(4)) i_rsw_reset_watchdog (
    .clk(clk), .rst_b(rst_b), .cpu_wr_en(cpu_wr_en), .cpu_rd_en(cpu_rd_en),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .bdm_wr_en(bdm_wr_en), .bdm_addr(bdm_addr), .bdm_wdata(bdm_wdata),
    .background_mode_enable(1'b0), .illegal_opcode(src[0]), .stop_exec(src[3]),
    .enter_background_instruction(src[4]), .illegal_address(src[1]),
    .clock_loss(src[2]), .reset_pin_b(~src[5]), .low_voltage_trip(src[6]),
    .low_voltage_reset_enable(1'b1), .mcu_reset(mcu_reset), .stop_allow(stop_allow),
    .serial2_pin_location(serial2_pin_location), .i2c_pin_location(i2c_pin_location),
    .watchdog_enable(watchdog_enable));

  rsw_debug_host i_rsw_debug_host (
    .clk(clk), .bdm_wr_en(bdm_wr_en), .bdm_addr(bdm_addr), .bdm_wdata(bdm_wdata));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {cpu_wr_en, cpu_addr, cpu_wdata} = {1'b1, a, d};
    @(negedge clk);
    cpu_wr_en = 1'b0;
  endtask

  task automatic rdreg(input logic [7:0] a);
    @(negedge clk);
    {cpu_rd_en, cpu_addr} = {1'b1, a};
    @(negedge clk);
    cpu_rd_en = 1'b0;
    @(negedge clk);
    rd = cpu_rdata;
  endtask

  // Reset pulse length is fixed at eight cycles, so it is checked every time
  task automatic wait_reset;
    int n;
    lat = 0;
    n   = 0;
    while (mcu_reset !== 1'b1 && lat < 300) begin
      @(negedge clk);
      lat++;
    end
    while (mcu_reset === 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n), 8'h08);
    repeat (2) @(negedge clk);
  endtask

  task automatic quiet(input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(negedge clk);
      seen = seen | (mcu_reset === 1'b1);
    end
    chk({7'h00, seen}, 8'h00);
  endtask

  task automatic t_por;
    rdreg(rsw_pkg::OFS_CAUSE);
    chk(rd, 8'h82);
    rdreg(rsw_pkg::OFS_OPT1);
    chk(rd, 8'hc0);
    rdreg(rsw_pkg::OFS_DEBUG);
    chk(rd, 8'h00);
  endtask

  task automatic t_timeout;
    wr(rsw_pkg::OFS_OPT1, 8'h78);
    wr(rsw_pkg::OFS_OPT1, 8'h00);
    rdreg(rsw_pkg::OFS_OPT1);
    chk(rd, 8'h78);
    chk({5'h00, stop_allow, serial2_pin_location, i2c_pin_location}, 8'h07);
    wr(rsw_pkg::OFS_CAUSE, 8'h55);
    wr(rsw_pkg::OFS_CAUSE, 8'haa);
    rdreg(rsw_pkg::OFS_CAUSE);
    chk(rd, 8'h82);
    wait_reset();
    // Slow tick of 4 cycles: 32 ticks, less the 3 read cycles, tick phase unknown
    chk(8'((lat >= 116 && lat <= 130) ? 1 : 0), 8'h01);
    rdreg(rsw_pkg::OFS_CAUSE);
    chk(rd, 8'h20);
  endtask

  task automatic t_badkey;
    wr(rsw_pkg::OFS_CAUSE, 8'h12);
    wait_reset();
    chk(8'(lat), 8'h00);
    rdreg(rsw_pkg::OFS_CAUSE);
    chk(rd, 8'h20);
    rdreg(rsw_pkg::OFS_OPT1);
    chk(rd, 8'hc0);
  endtask

  task automatic t_disabled;
    wr(rsw_pkg::OFS_OPT1, 8'h20);
    chk({7'h00, watchdog_enable}, 8'h00);
    wr(rsw_pkg::OFS_CAUSE, 8'h12);
    src[3] = 1'b1;
    @(negedge clk);
    src[3] = 1'b0;
    quiet(20);
  endtask

  task automatic t_debug;
    wr(rsw_pkg::OFS_DEBUG, 8'h01);
    quiet(10);
    i_rsw_debug_host.write_byte(rsw_pkg::OFS_DEBUG, 8'h01);
    wait_reset();
    rdreg(rsw_pkg::OFS_CAUSE);
    chk(rd, 8'h00);
  endtask

  task automatic t_sources;
    logic [7:0] exp [7] = '{8'h10, 8'h08, 8'h04, 8'h10, 8'h10, 8'h40, 8'h02};
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      src[i] = 1'b1;
      // One-cycle pulse so the reset is seen from its first cycle
      @(negedge clk);
      src[i] = 1'b0;
      wait_reset();
      rdreg(rsw_pkg::OFS_CAUSE);
      chk(rd, exp[i]);
    end
  endtask

  task automatic t_window;
    wr(rsw_pkg::OFS_OPT2, 8'hc0);
    wr(rsw_pkg::OFS_OPT1, 8'h40);
    repeat (6250) @(negedge clk);
    wr(rsw_pkg::OFS_CAUSE, 8'h55);
    wr(rsw_pkg::OFS_CAUSE, 8'haa);
    quiet(20);
    wr(rsw_pkg::OFS_CAUSE, 8'h55);
    wait_reset();
    chk(8'(lat), 8'h00);
    rdreg(rsw_pkg::OFS_CAUSE);
    chk(rd, 8'h20);
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #(50 * 40000);
    miscompares++;
    end_sim();
  end

  initial begin
    {rst_b, cpu_wr_en, cpu_rd_en, cpu_addr, cpu_wdata, src} = '0;
    miscompares  = 0;
    total_checks = 0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_por();
    t_timeout();
    t_badkey();
    t_disabled();
    t_debug();
    t_sources();
    t_window();
    end_sim();
  end
endmodule // tb_top
